/* hw/eau_pkg.sv */
// constants, register map and state layout of the extended arithmetic unit
// assumes an axi4-lite master on the same clock and 18-bit words, bit 0 the msb
package eau_pkg;
    localparam int ADDR_W = 8;
    localparam int WORD_W = 18;
    localparam int STEP_W = 6;
    // register byte offsets
    localparam logic [7:0] OFF_INSTR = 8'h00;
    localparam logic [7:0] OFF_MAIN = 8'h04;
    localparam logic [7:0] OFF_QUOT = 8'h08;
    localparam logic [7:0] OFF_STEP = 8'h0C;
    localparam logic [7:0] OFF_LINK = 8'h10;
    localparam logic [7:0] OFF_STATUS = 8'h14;
    localparam logic [7:0] ADDR_WORD_MASK = 8'hFC;
    // status field positions
    localparam int ST_BUSY_BIT = 0;
    localparam int ST_DONE_BIT = 1;
    localparam int ST_SIGN_BIT = 2;
    // instruction word fields, vector index = 17 - documented bit number
    localparam int OP_HI = 8;
    localparam int OP_LO = 6;
    localparam int CNT_HI = 5;
    localparam int MAG_HI = 11;
    localparam int MAG_LO = 10;
    localparam int SIGN_CAP_BIT = 12;
    localparam int CPL_QUOT_BIT = 2;
    localparam int OR_QUOT_BIT = 1;
    localparam int OR_STEP_BIT = 0;
    localparam logic [2:0] OP_SETUP = 3'h0;
    localparam logic [2:0] OP_ALIGN = 3'h4;
    localparam logic [2:0] OP_ACC_SHL = 3'h7;
    localparam logic [1:0] MAG_SEL = 2'h2;
    localparam logic [17:0] SIGN_MAG_CODE = 18'o664000;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_SHIFT = 2'b10
    } state_t;

    typedef struct packed {
        state_t st;
        logic [17:0] instr;
        logic [17:0] main;
        logic [17:0] quot;
        logic [5:0] step;
        logic link;
        logic sign;
        logic align;
        logic done;
        logic aw_got;
        logic w_got;
        logic [7:0] awaddr;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } regs_t;

    localparam regs_t REGS_RST = '{
        st: ST_IDLE, instr: 18'h00000, main: 18'h00000, quot: 18'h00000, step: 6'h00,
        link: 1'b0, sign: 1'b0, align: 1'b0, done: 1'b0, aw_got: 1'b0, w_got: 1'b0,
        awaddr: 8'h00, wdata: 32'h00000000, wstrb: 4'h0, awready: 1'b1, wready: 1'b1,
        bvalid: 1'b0, bresp: 2'h0, arready: 1'b1, rvalid: 1'b0, rdata: 32'h00000000,
        rresp: 2'h0
    };
endpackage

/* hw/ext_arith_unit.sv */
// extended arithmetic unit: align, accumulator shift, setup and sign-magnitude ops
// assumes an axi4-lite master clocked by mclk; one write and one read in flight
`timescale 1ns/1ps

module ext_arith_unit (
    input wire logic mclk,
    input wire logic arst_n,
    input wire logic [eau_pkg::ADDR_W-1:0] s_axil_awaddr,
    input wire logic [2:0] s_axil_awprot,
    input wire logic s_axil_awvalid,
    output logic s_axil_awready,
    input wire logic [31:0] s_axil_wdata,
    input wire logic [3:0] s_axil_wstrb,
    input wire logic s_axil_wvalid,
    output logic s_axil_wready,
    output logic [1:0] s_axil_bresp,
    output logic s_axil_bvalid,
    input wire logic s_axil_bready,
    input wire logic [eau_pkg::ADDR_W-1:0] s_axil_araddr,
    input wire logic [2:0] s_axil_arprot,
    input wire logic s_axil_arvalid,
    output logic s_axil_arready,
    output logic [31:0] s_axil_rdata,
    output logic [1:0] s_axil_rresp,
    output logic s_axil_rvalid,
    input wire logic s_axil_rready
);
    import eau_pkg::*;

    regs_t r;
    regs_t n;
    logic [31:0] wv;
    logic [31:0] old_word;
    logic [7:0] wa;
    logic [7:0] ra;
    logic [17:0] ins;
    logic [17:0] main1;
    logic [17:0] quot1;
    logic busy;
    logic set_done;
    logic clr_done;

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] strb);
        logic [31:0] res;
        res = old;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                res[8*b +: 8] = nw[8*b +: 8];
            end
        end
        return res;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    always_comb begin
        n = r;
        wv = 32'h00000000;
        old_word = 32'h00000000;
        ins = 18'h00000;
        main1 = r.main;
        quot1 = r.quot;
        set_done = 1'b0;
        clr_done = 1'b0;
        busy = (r.st == ST_SHIFT);
        wa = r.awaddr & ADDR_WORD_MASK;
        ra = s_axil_araddr & ADDR_WORD_MASK;

        // shift engine; bus writes to instr, main, quot and link are refused while busy
        case (r.st)
            ST_IDLE: begin
            end
            ST_SHIFT: begin
                // the stop test comes before the shift, so an aligned word takes no step
                // stop on count or align
                if (r.step == 6'h00 || (r.align && r.main[17] != r.main[16])) begin
                    n.st = ST_IDLE;
                    set_done = 1'b1;
                end else begin
                    if (r.align) begin
                        {n.main, n.quot} = {r.main[16:0], r.quot, r.link};
                    end else begin
                        n.main = {r.main[16:0], r.link};
                    end
                    // starting at minus the count leaves shifts minus count behind
                    // count up toward zero
                    n.step = 6'(r.step + 6'h01);
                end
            end
            default: begin
                // a lost state code falls back to idle
                n.st = ST_IDLE;
            end
        endcase

        ////////////////////////////////////////////////////////////////////////
        // write address and data channels, taken in either order
        // both stay refused until the response is taken: one write in flight
        if (r.awready && s_axil_awvalid) begin
            n.aw_got = 1'b1;
            n.awready = 1'b0;
            n.awaddr = s_axil_awaddr;
        end
        if (r.wready && s_axil_wvalid) begin
            n.w_got = 1'b1;
            n.wready = 1'b0;
            n.wdata = s_axil_wdata;
            n.wstrb = s_axil_wstrb;
        end

        if (r.aw_got && r.w_got && !r.bvalid) begin
            n.aw_got = 1'b0;
            n.w_got = 1'b0;
            n.bvalid = 1'b1;
            n.bresp = RESP_OKAY;
            case (wa)
                OFF_INSTR: old_word = {14'h0000, r.instr};
                OFF_MAIN: old_word = {14'h0000, r.main};
                OFF_QUOT: old_word = {14'h0000, r.quot};
                OFF_LINK: old_word = {31'h00000000, r.link};
                default: old_word = 32'h00000000;
            endcase

            wv = merge(old_word, r.wdata, r.wstrb);
            case (wa)
                OFF_INSTR: begin
                    if (busy) begin
                        n.bresp = RESP_SLVERR;
                    end else begin
                        ins = wv[17:0];
                        n.instr = ins;
                        if (ins == SIGN_MAG_CODE) begin
                            // this code moves the sign to the link only; the sign register keeps its value
                            // sign to link, then magnitude
                            n.link = r.main[17];
                            if (r.main[17]) begin
                                main1 = ~r.main;
                            end
                        end else begin
                            if (ins[SIGN_CAP_BIT] || ins[MAG_HI:MAG_LO] == MAG_SEL) begin
                                n.sign = r.main[17];
                            end

                            if (ins[MAG_HI:MAG_LO] == MAG_SEL && r.main[17]) begin
                                main1 = ~r.main;
                            end
                        end

                        case (ins[OP_HI:OP_LO])
                            OP_SETUP: begin
                                // complement first, so the or below sees the new quotient
                                // complement quotient
                                if (ins[CPL_QUOT_BIT]) begin
                                    quot1 = ~r.quot;
                                end
                                if (ins[OR_QUOT_BIT]) begin
                                    main1 = main1 | quot1;
                                end
                                if (ins[OR_STEP_BIT]) begin
                                    main1[5:0] = main1[5:0] | r.step;
                                end
                                set_done = 1'b1;
                            end
                            OP_ALIGN, OP_ACC_SHL: begin
                                n.step = 6'(6'h00 - ins[CNT_HI:0]);
                                n.align = (ins[OP_HI:OP_LO] == OP_ALIGN);
                                n.st = ST_SHIFT;
                            end
                            default: begin
                                // other operation codes belong to neighbouring logic
                                set_done = 1'b1;
                            end
                        endcase

                        n.main = main1;
                        n.quot = quot1;
                    end
                end

                OFF_MAIN: begin
                    if (busy) begin
                        n.bresp = RESP_SLVERR;
                    end else begin
                        n.main = wv[17:0];
                    end
                end

                OFF_QUOT: begin
                    if (busy) begin
                        n.bresp = RESP_SLVERR;
                    end else begin
                        n.quot = wv[17:0];
                    end
                end

                OFF_LINK: begin
                    if (busy) begin
                        n.bresp = RESP_SLVERR;
                    end else begin
                        n.link = wv[0];
                    end
                end

                OFF_STATUS: begin
                    if (r.wstrb[0] && r.wdata[ST_DONE_BIT]) begin
                        clr_done = 1'b1;
                    end
                end

                OFF_STEP: begin
                    // counter is read only; write is accepted and ignored
                end
                default: begin
                    // unmapped words answer with an error and change nothing
                    n.bresp = RESP_SLVERR;
                end
            endcase
        end

        if (r.bvalid && s_axil_bready) begin
            n.bvalid = 1'b0;
            n.awready = 1'b1;
            n.wready = 1'b1;
        end

        // done is not cleared by a new instruction; software clears it
        // set wins over a software clear in the same cycle
        n.done = (r.done & ~clr_done) | set_done;

        ////////////////////////////////////////////////////////////////////////
        // read channel, one cycle from address to data
        // arready stays low until the data is taken: one read in flight
        if (r.arready && s_axil_arvalid) begin
            n.arready = 1'b0;
            n.rvalid = 1'b1;
            n.rresp = RESP_OKAY;
            case (ra)
                OFF_INSTR: n.rdata = {14'h0000, r.instr};
                OFF_MAIN: n.rdata = {14'h0000, r.main};
                OFF_QUOT: n.rdata = {14'h0000, r.quot};
                OFF_STEP: n.rdata = {26'h0000000, r.step};
                OFF_LINK: n.rdata = {31'h00000000, r.link};
                OFF_STATUS: n.rdata = {29'h00000000, r.sign, r.done, busy};
                default: begin
                    n.rdata = 32'h00000000;
                    n.rresp = RESP_SLVERR;
                end
            endcase
        end

        if (r.rvalid && s_axil_rready) begin
            n.rvalid = 1'b0;
            n.arready = 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // reset leaves the bus ready, the engine idle and every register zero
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            r <= REGS_RST;
        end else begin
            r <= n;
        end
    end

    // prot signals carry no meaning for this register file
    assign s_axil_awready = r.awready;
    assign s_axil_wready = r.wready;
    assign s_axil_bvalid = r.bvalid;
    assign s_axil_bresp = r.bresp;
    assign s_axil_arready = r.arready;
    assign s_axil_rvalid = r.rvalid;
    assign s_axil_rdata = r.rdata;
    assign s_axil_rresp = r.rresp;
endmodule

/* bench/ext_arith_unit_properties.sv */
// bus handshake properties of the extended arithmetic unit
// sees only the unit's ports; bound to it at the foot
`timescale 1ns/1ps
module ext_arith_unit_properties (
    input wire logic mclk,
    input wire logic arst_n,
    input wire logic s_axil_awvalid,
    input wire logic s_axil_awready,
    input wire logic s_axil_wvalid,
    input wire logic s_axil_wready,
    input wire logic [1:0] s_axil_bresp,
    input wire logic s_axil_bvalid,
    input wire logic s_axil_bready,
    input wire logic s_axil_arvalid,
    input wire logic s_axil_arready,
    input wire logic [31:0] s_axil_rdata,
    input wire logic s_axil_rvalid,
    input wire logic s_axil_rready
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!arst_n);
    chk_b_stands: assert property (
        s_axil_bvalid && !s_axil_bready |=> s_axil_bvalid && $stable(s_axil_bresp)) else $error("b dropped");
    chk_r_stands: assert property (
        s_axil_rvalid && !s_axil_rready |=> s_axil_rvalid && $stable(s_axil_rdata)) else $error("r dropped");
    chk_write_answer: assert property (
        s_axil_awvalid && s_axil_awready && s_axil_wvalid && s_axil_wready |=> !s_axil_bvalid ##1 s_axil_bvalid)
        else $error("b late");
    chk_read_answer: assert property (
        s_axil_arvalid && s_axil_arready |=> s_axil_rvalid) else $error("r late");
    chk_w_refused: assert property (
        s_axil_bvalid |-> !s_axil_awready && !s_axil_wready) else $error("write taken early");
    chk_ar_refused: assert property (
        s_axil_rvalid |-> !s_axil_arready) else $error("read taken early");
    chk_word_width: assert property (
        s_axil_rvalid |-> s_axil_rdata[31:18] == 14'h0000) else $error("upper bits set");
    chk_b_release: assert property (
        s_axil_bvalid && s_axil_bready |=> !s_axil_bvalid && s_axil_awready) else $error("b stuck");
endmodule
////////////////////////////////////////////////////////////////////////////////
bind ext_arith_unit ext_arith_unit_properties chk (.mclk, .arst_n, .s_axil_awvalid, .s_axil_awready,
    .s_axil_wvalid, .s_axil_wready, .s_axil_bresp, .s_axil_bvalid, .s_axil_bready, .s_axil_arvalid,
    .s_axil_arready, .s_axil_rdata, .s_axil_rvalid, .s_axil_rready);

/* bench/cpu_model.sv */
// bus master standing in for the issuing processor
// assumes the unit samples on rising mclk; one write and one read at a time
`timescale 1ns/1ps
module cpu_model (
    input wire logic mclk,
    output logic [7:0] awaddr,
    output logic awvalid,
    input wire logic awready,
    output logic [31:0] wdata,
    output logic wvalid,
    input wire logic wready,
    input wire logic [1:0] bresp,
    input wire logic bvalid,
    output logic bready,
    output logic [7:0] araddr,
    output logic arvalid,
    input wire logic arready,
    input wire logic [31:0] rdata,
    input wire logic [1:0] rresp,
    input wire logic rvalid,
    output logic rready
);
    initial begin
        {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
        {awaddr, araddr, wdata} = 48'h0;
    end
    task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        @(posedge mclk);
        {awaddr, wdata} <= {a, d};
        {awvalid, wvalid, bready} <= 3'h7;
        do begin
            @(posedge mclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        r = bresp;
        bready <= 1'b0;
        // released payload must not look valid
        {awaddr, wdata} <= ~{a, d};
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge mclk);
        araddr <= a;
        {arvalid, rready} <= 2'h3;
        do begin
            @(posedge mclk);
            if (arready) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        {d, r} = {rdata, rresp};
        {rready, araddr} <= {1'b0, ~a};
    endtask
endmodule

/* bench/ext_arith_unit_bench.sv */
// self-checking bench of the extended arithmetic unit
// assumes cpu_model as bus master and the bound property checker
`timescale 1ns/1ps
module ext_arith_unit_bench;
    import eau_pkg::*;
    logic mclk = 1'b0;
    logic arst_n = 1'b0;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata, seen;
    logic [1:0] bresp, rresp, resp;
    logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
    logic [17:0] e_main, e_quot;
    logic [5:0] e_step = 6'h00;
    logic e_link, e_sign = 1'b0;
    int mismatches = 0, n_compared = 0;
    always #20 mclk = ~mclk;
    ext_arith_unit dut (.mclk(mclk), .arst_n(arst_n), .s_axil_awaddr(awaddr), .s_axil_awprot(3'h0),
        .s_axil_awvalid(awvalid), .s_axil_awready(awready), .s_axil_wdata(wdata), .s_axil_wstrb(4'hF),
        .s_axil_wvalid(wvalid), .s_axil_wready(wready), .s_axil_bresp(bresp), .s_axil_bvalid(bvalid),
        .s_axil_bready(bready), .s_axil_araddr(araddr), .s_axil_arprot(3'h0), .s_axil_arvalid(arvalid),
        .s_axil_arready(arready), .s_axil_rdata(rdata), .s_axil_rresp(rresp), .s_axil_rvalid(rvalid),
        .s_axil_rready(rready));
    cpu_model u_cpu (.mclk, .awaddr, .awvalid, .awready, .wdata, .wvalid, .wready, .bresp, .bvalid, .bready,
        .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready);
    task automatic check(input string what, input logic [31:0] s, input logic [31:0] e);
        n_compared++;
        mismatches += int'(s !== e);
        if (s !== e) $display("mismatch %s expected %h seen %h", what, e, s);
    endtask
    task automatic final_report();
        if (mismatches == 0 && n_compared > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic rchk(input string what, input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
        u_cpu.rd(a, seen, resp);
        check(what, seen, e);
        check({what, " resp"}, {30'h0, resp}, {30'h0, er});
    endtask
    // loads operands, issues one word, predicts the result bit by bit
    task automatic run(input logic [17:0] ins, input logic [17:0] m, input logic [17:0] q, input logic l,
                       input bit poke);
        logic al, sh;
        u_cpu.wr(OFF_MAIN, {14'h0, m}, resp);
        u_cpu.wr(OFF_QUOT, {14'h0, q}, resp);
        u_cpu.wr(OFF_LINK, {31'h0, l}, resp);
        u_cpu.wr(OFF_STATUS, 32'h2, resp);
        u_cpu.wr(OFF_INSTR, {14'h0, ins}, resp);
        if (poke) u_cpu.wr(OFF_MAIN, 32'h0, resp);
        if (poke) check("busy write", {30'h0, resp}, {30'h0, RESP_SLVERR});
        {e_main, e_quot, e_link} = {m, q, l};
        al = (ins[OP_HI:OP_LO] == OP_ALIGN);
        sh = al || ins[OP_HI:OP_LO] == OP_ACC_SHL;
        if (ins == SIGN_MAG_CODE)
            e_link = e_main[17];
        else if (ins[MAG_HI:MAG_LO] == MAG_SEL || ins[SIGN_CAP_BIT])
            e_sign = e_main[17];
        if (e_main[17] && (ins == SIGN_MAG_CODE || ins[MAG_HI:MAG_LO] == MAG_SEL)) e_main = ~e_main;
        if (ins[OP_HI:OP_LO] == OP_SETUP) begin
            if (ins[CPL_QUOT_BIT]) e_quot = ~e_quot;
            if (ins[OR_QUOT_BIT]) e_main = e_main | e_quot;
            if (ins[OR_STEP_BIT]) e_main[5:0] = e_main[5:0] | e_step;
        end
        if (sh) e_step = -ins[CNT_HI:0];
        while (sh && e_step != 6'h00 && !(al && e_main[17] != e_main[16])) begin
            e_main = {e_main[16:0], al ? e_quot[17] : e_link};
            if (al) e_quot = {e_quot[16:0], e_link};
            e_step++;
        end
        seen = 32'h1;
        repeat (80) if (seen[ST_BUSY_BIT] !== 1'b0) u_cpu.rd(OFF_STATUS, seen, resp);
        rchk("main", OFF_MAIN, {14'h0, e_main}, RESP_OKAY);
        rchk("quot", OFF_QUOT, {14'h0, e_quot}, RESP_OKAY);
        rchk("link", OFF_LINK, {31'h0, e_link}, RESP_OKAY);
        rchk("step", OFF_STEP, {26'h0, e_step}, RESP_OKAY);
        rchk("status", OFF_STATUS, {29'h0, e_sign, 2'b10}, RESP_OKAY);
    endtask
    initial begin
        repeat (20000) @(posedge mclk);
        mismatches++;
        final_report();
    end
    initial begin
        repeat (3) @(posedge mclk);
        arst_n <= 1'b1;
        rchk("main at reset", OFF_MAIN, 32'h0, RESP_OKAY);
        rchk("unmapped", 8'h20, 32'h0, RESP_SLVERR);
        run(18'o640444, 18'h00001, 18'h00000, 1'b1, 1'b1);
        run(18'o640001, 18'h10000, 18'h00000, 1'b0, 1'b0);
        run(18'o640405, 18'h20000, 18'h3FFFF, 1'b0, 1'b0);
        run(18'o640007, 18'h00000, 18'h3F0F0, 1'b0, 1'b0);
        run(18'o640403, 18'h00000, 18'h12345, 1'b1, 1'b0);
        run(18'o640703, 18'h2AAAA, 18'h15555, 1'b1, 1'b0);
        run(18'o640700, 18'h2AAAA, 18'h15555, 1'b1, 1'b0);
        run(18'o640777, 18'h12345, 18'h00000, 1'b0, 1'b0);
        run(18'o640004, 18'h00F00, 18'h0F0F0, 1'b0, 1'b0);
        run(18'o640002, 18'h00F00, 18'h0F0F0, 1'b1, 1'b0);
        run(18'o664000, 18'h30000, 18'h00000, 1'b0, 1'b0);
        run(18'o664000, 18'h01234, 18'h00000, 1'b1, 1'b0);
        run(18'o644000, 18'h3FFF0, 18'h00000, 1'b0, 1'b0);
        u_cpu.wr(OFF_STEP, 32'h15, resp);
        rchk("step kept", OFF_STEP, {26'h0, e_step}, RESP_OKAY);
        u_cpu.wr(8'h20, 32'h1, resp);
        check("unmapped write", {30'h0, resp}, {30'h0, RESP_SLVERR});
        final_report();
    end
endmodule
